// [rtl/icu_pkg.sv]
/*
  Constants for the interrupt configuration and update logic.
  Assumes a single clock domain and a small fixed set of interrupt sources.
*/
package icu_pkg;
  localparam int NUM_IRQ         = 8;
  localparam int ID_W            = 10;
  localparam int PRIO_W          = 8;
  localparam int NUM_CPU         = 2;
  localparam logic [ID_W-1:0]   SPURIOUS_ID     = 10'h3ff;
  localparam logic [PRIO_W-1:0] PRIO_SILENT     = 8'hff;
  localparam logic [PRIO_W-1:0] PRIO_RESET      = 8'h00;
  localparam logic [NUM_CPU-1:0] TARGET_RESET   = 2'h0;
  localparam logic [PRIO_W-1:0] PMASK_RESET     = 8'h00;
  localparam logic [NUM_IRQ-1:0] PERM_ENABLED   = 8'h01;
  // Field selectors of the configuration write port
  localparam logic [2:0] CMD_NONE     = 3'h0;
  localparam logic [2:0] CMD_PRIO     = 3'h1;
  localparam logic [2:0] CMD_TARGET   = 3'h2;
  localparam logic [2:0] CMD_SET_EN   = 3'h3;
  localparam logic [2:0] CMD_CLR_EN   = 3'h4;
  localparam logic [2:0] CMD_SET_PEND = 3'h5;
  localparam logic [2:0] CMD_CLR_PEND = 3'h6;
  localparam logic [2:0] CMD_GROUP    = 3'h7;
endpackage

// [rtl/icu_top.sv]
/*
  Interrupt configuration and update logic: per-interrupt priority, targets,
  enable, pending, active and security group, plus per-CPU signalling and
  acknowledge. Assumes synchronous inputs and one-cycle command strobes.
  An acknowledge answer, ack_valid with ack_id, stands two clocks after its strobe.
*/
`timescale 1ns/10ps

// Function
// - Priority writes change one interrupt's byte only.
// - Non-secure priority writes affect non-secure interrupts only.
// - Highest pending choice recomputed whenever priorities change.
// - Target writes change one interrupt's byte only.
// - Non-secure target writes affect non-secure interrupts only.
// - Clear-enable disables, active state untouched; here fixed-enable source 0 stays enabled.
// - Disabled interrupts still go pending but are not forwarded.
// - Already-acknowledged interrupt stays active until completed.
// - Clear-pending removes pending; level source must be low first; here sources are edge-only and clear works with the line high.
// - Priority 0xff never signals.
// - Only secure writes change the security group.
// - Set and clear pending reads both give pending state.
// - Active bits read back current active state.
// - Set-enable enables forwarding to targets.
// - Acknowledge returns spurious when nothing pending, else acknowledges.
// - Secure acks see secure, non-secure acks see non-secure interrupts.
// - Writing zero to CPU interface enable stops signalling.
// - Smaller priority value means higher priority.
// - Priority at or below the mask is never signalled.
module icu_top
  import icu_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Configuration write port
  input  wire logic                cfg_wr,
  input  wire logic [2:0]          cfg_cmd,
  input  wire logic                cfg_secure,
  input  wire logic [2:0]          cfg_irq,
  input  wire logic [PRIO_W-1:0]   cfg_data,
  // Peripheral lines
  input  wire logic [NUM_IRQ-1:0]  irq_line,
  // CPU interface control and handshake
  input  wire logic [NUM_CPU-1:0]  cpu_if_enable,
  input  wire logic [NUM_CPU-1:0]  cpu_if_enable_wr,
  input  wire logic [PRIO_W-1:0]   pmask_data,
  input  wire logic [NUM_CPU-1:0]  pmask_wr,
  input  wire logic [NUM_CPU-1:0]  ack_rd,
  input  wire logic [NUM_CPU-1:0]  ack_secure,
  input  wire logic [NUM_CPU-1:0]  eoi_wr,
  input  wire logic [2:0]          eoi_irq,
  // Status read-back
  output logic [NUM_IRQ-1:0]       set_enable_bits,
  output logic [NUM_IRQ-1:0]       set_pending_bits,
  output logic [NUM_IRQ-1:0]       clear_pending_bits,
  output logic [NUM_IRQ-1:0]       active_state_bits,
  output logic [NUM_IRQ-1:0]       security_group_bits,
  output logic [NUM_IRQ*PRIO_W-1:0] interrupt_priority_bytes,
  output logic [NUM_IRQ*NUM_CPU-1:0] cpu_target_bytes,
  // Per-CPU results
  output logic [NUM_CPU-1:0]       irq_out,
  output logic [NUM_CPU*ID_W-1:0]  ack_id,
  output logic [NUM_CPU-1:0]       ack_valid
);

  // Per-interrupt and per-CPU state; enable, pending, active, group, prio, target, cpu_en and pmask beside their next_ values
  logic                rst_meta;
  logic                rst_sync_n;
  logic [NUM_IRQ-1:0]  enable, next_enable;
  logic [NUM_IRQ-1:0]  pending, next_pending;
  logic [NUM_IRQ-1:0]  active, next_active;
  logic [NUM_IRQ-1:0]  group_ns, next_group_ns; // 1 = non-secure
  logic [PRIO_W-1:0]   prio [NUM_IRQ];
  logic [PRIO_W-1:0]   next_prio [NUM_IRQ];
  logic [NUM_CPU-1:0]  target [NUM_IRQ];
  logic [NUM_CPU-1:0]  next_target [NUM_IRQ];
  logic [NUM_CPU-1:0]  cpu_en, next_cpu_en;
  logic [PRIO_W-1:0]   pmask [NUM_CPU];
  logic [PRIO_W-1:0]   next_pmask [NUM_CPU];
  logic [NUM_IRQ-1:0]  irq_line_q;
  logic [NUM_CPU-1:0]  next_irq_out;
  logic [ID_W-1:0]     next_ack_id [NUM_CPU];
  logic [NUM_CPU-1:0]  next_ack_valid;
  logic [NUM_CPU-1:0]  ack_valid_r;     // Held back one clock to meet ack_id
  logic [ID_W-1:0]     ack_id_r [NUM_CPU];
  logic                cfg_allowed;
  logic [NUM_IRQ-1:0]  line_rise;

  // Only rising edges pend; a line held high pends once until it drops
  assign line_rise = irq_line & ~irq_line_q;

  // Assert at once, release on the clock so no flop sees a half-gone reset
  // Reset release through two flops; the first takes a constant, the second copies the first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Equal priorities: the lower index wins, the compare is strict
  // Best candidate for one CPU within one security group
  // smaller wins
  function automatic logic [3:0] pick_best(input logic [NUM_IRQ-1:0] cand,
                                           input logic [PRIO_W-1:0] pr [NUM_IRQ],
                                           input logic [PRIO_W-1:0] mask);
    logic [3:0]        best;
    logic [PRIO_W-1:0] best_p;
    best   = 4'h8;
    best_p = mask;
    for (int i = 0; i < NUM_IRQ; i++) begin
      // strictly above mask, 0xff never wins
      if (cand[i] && pr[i] < best_p && pr[i] != PRIO_SILENT) begin
        best   = 4'(i);
        best_p = pr[i];
      end
    end
    return best;
  endfunction

  // Marker for no winner is one past the last index
  function automatic logic no_pick(input logic [3:0] idx);
    return idx == 4'h8;
  endfunction

  // Configuration and interrupt state update
  always_comb begin
    next_enable   = enable;
    next_pending  = pending;
    next_active   = active;
    next_group_ns = group_ns;
    next_cpu_en   = cpu_en;
    for (int i = 0; i < NUM_IRQ; i++) begin
      next_prio[i]   = prio[i];
      next_target[i] = target[i];
    end
    for (int c = 0; c < NUM_CPU; c++) begin
      next_pmask[c] = pmask_wr[c] ? pmask_data : pmask[c];
    end
    // Completion ends the active state
    for (int c = 0; c < NUM_CPU; c++) begin
      if (eoi_wr[c]) next_active[eoi_irq] = 1'b0;
    end
    // Acknowledge moves the chosen interrupt to active; spurious reads change nothing
    for (int c = 0; c < NUM_CPU; c++) begin
      if (ack_rd[c] && next_ack_id[c] != SPURIOUS_ID) begin
        next_pending[next_ack_id[c][2:0]] = 1'b0;
        next_active[next_ack_id[c][2:0]]  = 1'b1;
      end
    end
    // A new edge beats an acknowledge in the same cycle
    next_pending = next_pending | line_rise;
    cfg_allowed = cfg_secure || group_ns[cfg_irq];
    // Refused writes vanish silently; nothing flags them
    if (cfg_wr && cfg_allowed) begin
      case (cfg_cmd)
        CMD_PRIO:     next_prio[cfg_irq] = cfg_data;
        CMD_TARGET:   next_target[cfg_irq] = cfg_data[NUM_CPU-1:0];
        CMD_SET_EN:   next_enable[cfg_irq] = 1'b1;
        CMD_CLR_EN:   next_enable[cfg_irq] = PERM_ENABLED[cfg_irq];
        CMD_SET_PEND: next_pending[cfg_irq] = 1'b1;
        // remove pending unless new edge same cycle
        CMD_CLR_PEND: next_pending[cfg_irq] = irq_line[cfg_irq] & ~irq_line_q[cfg_irq];
        CMD_GROUP:    if (cfg_secure) next_group_ns[cfg_irq] = cfg_data[0];
        default:      ;
      endcase
    end
    for (int c = 0; c < NUM_CPU; c++) begin
      if (cpu_if_enable_wr[c]) next_cpu_en[c] = cpu_if_enable[c];
    end
    // Fixed-enable sources cannot be turned off by any path
    next_enable = next_enable | PERM_ENABLED;
  end

  // Per-CPU signalling and acknowledge
  always_comb begin
    logic [NUM_IRQ-1:0] cand;
    logic [NUM_IRQ-1:0] grp;
    logic [3:0]         best;
    logic [3:0]         best_s;
    logic [3:0]         best_n;
    cand = '0;
    grp  = '0;
    best = 4'h8;
    best_s = 4'h8;
    best_n = 4'h8;
    next_irq_out   = '0;
    next_ack_valid = '0;
    // Both CPUs may win the same interrupt in one cycle; both then see it
    for (int c = 0; c < NUM_CPU; c++) begin
      next_ack_id[c] = ack_id_r[c];
      // only enabled, idle, targeted interrupts forwarded
      for (int i = 0; i < NUM_IRQ; i++) begin
        cand[i] = pending[i] && enable[i] && !active[i] && target[i][c];
      end
      // A new priority on an active interrupt is taken at once; the interrupt rejoins the choice when it completes
      // re-evaluated every cycle from live priorities
      best_s = pick_best(cand & ~group_ns, prio, pmask[c]);
      best_n = pick_best(cand & group_ns, prio, pmask[c]);
      next_irq_out[c] = cpu_en[c] && (!no_pick(best_s) || !no_pick(best_n));
      if (ack_rd[c]) begin
        next_ack_valid[c] = 1'b1;
        // security of the read picks the group
        grp  = ack_secure[c] ? ~group_ns : group_ns;
        best = ack_secure[c] ? best_s : best_n;
        if (!cpu_en[c] || no_pick(best) || grp == '0) begin
          next_ack_id[c] = SPURIOUS_ID;
        end else begin
          next_ack_id[c] = ID_W'(best);
        end
      end
    end
  end

  // Register all state
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      enable     <= PERM_ENABLED;
      pending    <= '0;
      active     <= '0;
      group_ns   <= '0;
      cpu_en     <= '0;
      irq_line_q <= '0;
      irq_out    <= '0;
      ack_valid_r <= '0;
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio[i]   <= PRIO_RESET;
        target[i] <= TARGET_RESET;
      end
      for (int c = 0; c < NUM_CPU; c++) begin
        pmask[c]    <= PMASK_RESET;
        ack_id_r[c] <= SPURIOUS_ID;
      end
    end else begin
      enable     <= next_enable;
      pending    <= next_pending;
      active     <= next_active;
      group_ns   <= next_group_ns;
      cpu_en     <= next_cpu_en;
      irq_line_q <= irq_line;
      irq_out    <= next_irq_out;
      ack_valid_r <= next_ack_valid;
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio[i]   <= next_prio[i];
        target[i] <= next_target[i];
      end
      for (int c = 0; c < NUM_CPU; c++) begin
        pmask[c]    <= next_pmask[c];
        ack_id_r[c] <= next_ack_id[c];
      end
    end
  end

  // Read-back lags the state by one clock; pollers see it a cycle late
  // Read-back flops; both pending views, active
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      set_enable_bits          <= '0;
      set_pending_bits         <= '0;
      clear_pending_bits       <= '0;
      active_state_bits        <= '0;
      security_group_bits      <= '0;
      interrupt_priority_bytes <= '0;
      cpu_target_bytes         <= '0;
      ack_id                   <= '0;
      ack_valid                <= '0;
    end else begin
      set_enable_bits     <= enable;
      set_pending_bits    <= pending;
      clear_pending_bits  <= pending;
      active_state_bits   <= active;
      security_group_bits <= group_ns;
      for (int i = 0; i < NUM_IRQ; i++) begin
        interrupt_priority_bytes[i*PRIO_W +: PRIO_W] <= prio[i];
        cpu_target_bytes[i*NUM_CPU +: NUM_CPU]       <= target[i];
      end
      for (int c = 0; c < NUM_CPU; c++) begin
        ack_id[c*ID_W +: ID_W] <= ack_id_r[c];
      end
      ack_valid <= ack_valid_r;
    end
  end

endmodule

// [tb/icu_sva.sv]
/*
  Port checker for icu_top: read-back timing, security filters, acknowledge.
  Assumes one clock domain; bound to every icu_top below.
*/
`timescale 1ns/10ps
module icu_sva
  import icu_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        cfg_wr,
  input wire logic [2:0]  cfg_cmd,
  input wire logic        cfg_secure,
  input wire logic [2:0]  cfg_irq,
  input wire logic [7:0]  cfg_data,
  input wire logic [1:0]  ack_rd,
  input wire logic [1:0]  eoi_wr,
  // Outputs watched
  input wire logic [7:0]  set_enable_bits,
  input wire logic [7:0]  set_pending_bits,
  input wire logic [7:0]  clear_pending_bits,
  input wire logic [7:0]  active_state_bits,
  input wire logic [7:0]  security_group_bits,
  input wire logic [63:0] interrupt_priority_bytes,
  input wire logic [1:0]  irq_out,
  input wire logic [1:0]  ack_valid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Write that passes the filter; every priority silenced
  logic ok;
  logic quiet;
  assign ok = cfg_wr && (cfg_secure || security_group_bits[cfg_irq]);
  assign quiet = interrupt_priority_bytes == {8{PRIO_SILENT}};
  property p_prio;
    ok && cfg_cmd == CMD_PRIO |-> ##2 interrupt_priority_bytes[$past(cfg_irq, 2)*8 +: 8] == $past(cfg_data, 2);
  endproperty
  a_prio: assert property (p_prio) else $error("priority byte wrong");
  property p_grp;
    cfg_wr && cfg_cmd == CMD_GROUP && !cfg_secure ##1 !cfg_wr |=> $stable(security_group_bits);
  endproperty
  a_grp: assert property (p_grp) else $error("group changed by plain write");
  property p_off;
    ok && cfg_cmd == CMD_CLR_EN && cfg_irq != 3'h0 |-> ##2 !set_enable_bits[$past(cfg_irq, 2)];
  endproperty
  a_off: assert property (p_off) else $error("clear enable ignored");
  property p_keep;
    cfg_wr && cfg_cmd == CMD_CLR_EN && active_state_bits[cfg_irq] && !eoi_wr && !$past(eoi_wr)
      |-> ##2 active_state_bits[$past(cfg_irq, 2)];
  endproperty
  a_keep: assert property (p_keep) else $error("disable dropped active");
  property p_perm;
    rst_n [*5] |-> set_enable_bits[0];
  endproperty
  a_perm: assert property (p_perm) else $error("fixed enable lost");
  property p_quiet;
    quiet && $past(quiet) |-> irq_out == 2'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("silent priority signalled");
  property p_ack;
    ack_valid[0] == $past(ack_rd[0], 2);
  endproperty
  a_ack: assert property (p_ack) else $error("ack answer mistimed");
  property p_pend;
    set_pending_bits == clear_pending_bits;
  endproperty
  a_pend: assert property (p_pend) else $error("pending views differ");
  // Main scenarios reached
  c_ack: cover property (ack_valid[0]);
  c_irq: cover property (irq_out[0]);
  c_quiet: cover property (quiet);
endmodule
bind icu_top icu_sva icu_sva_i (.*);

// [tb/icu_periph.sv]
/*
  Peripheral line model facing the controller.
  Assumes the bench sets wanted levels; lines are registered sources.
*/
`timescale 1ns/10ps
module icu_periph
  import icu_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Wanted levels, driven lines
  input  wire logic [NUM_IRQ-1:0] want,
  output logic      [NUM_IRQ-1:0] irq_line
);
  // drops line on request
  // Registered, so lines never move on the sampling edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irq_line <= '0;
    else irq_line <= want;
  end
endmodule

// [tb/icu_top_tb.sv]
/*
  Bench for icu_top: strobed commands, read-back and acknowledge checks.
  Assumes icu_periph drives the lines and icu_sva is bound to the design.
*/
`timescale 1ns/10ps
module icu_top_tb;
  import icu_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_secure = 1'b0;
  logic [2:0]  cfg_cmd = 3'h0, cfg_irq = 3'h0, eoi_irq = 3'h0;
  logic [7:0]  cfg_data = 8'h0, pmask_data = 8'h0, want = 8'h0, irq_line;
  logic [1:0]  cpu_if_enable = 2'h0, cpu_if_enable_wr = 2'h0, pmask_wr = 2'h0;
  logic [1:0]  ack_rd = 2'h0, ack_secure = 2'h0, eoi_wr = 2'h0, irq_out, ack_valid;
  logic [7:0]  set_enable_bits, set_pending_bits, clear_pending_bits, active_state_bits, security_group_bits;
  logic [63:0] interrupt_priority_bytes;
  logic [15:0] cpu_target_bytes;
  logic [19:0] ack_id;
  int          n_fail = 0;
  int          n_checks = 0;
  // 25 MHz clock
  always #20 clock = ~clock;
  icu_top icu_top_i (.*);
  icu_periph icu_periph_i (.*);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One strobe: 0 config, 1 ack, 2 cpu control, 3 completion; waits for read-back
  task automatic op(input int k, input logic [2:0] c, input logic s, input logic [2:0] i, input logic [7:0] d);
    @(posedge clock);
    {cfg_cmd, cfg_secure, cfg_irq, cfg_data} <= {c, s, i, d};
    {ack_secure, eoi_irq, pmask_data, cpu_if_enable} <= {1'b0, s, i, d, 1'b0, c[0]};
    cfg_wr <= k == 0;
    ack_rd <= {1'b0, k == 1};
    eoi_wr <= {1'b0, k == 3};
    {cpu_if_enable_wr, pmask_wr} <= {1'b0, k == 2, 1'b0, k == 2};
    @(posedge clock);
    {cfg_wr, ack_rd, eoi_wr, cpu_if_enable_wr, pmask_wr} <= '0;
    wt(1);
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    wt(4);
    chk(set_enable_bits, 64'h01);
    op(0, CMD_PRIO, 1'b1, 3'h3, 8'h5a);
    chk(interrupt_priority_bytes, 64'h5a000000);
    op(0, CMD_PRIO, 1'b0, 3'h3, 8'h11);
    chk(interrupt_priority_bytes, 64'h5a000000);
    op(0, CMD_GROUP, 1'b0, 3'h3, 8'h01);
    chk(security_group_bits, 64'h00);
    op(0, CMD_GROUP, 1'b1, 3'h3, 8'h01);
    chk(security_group_bits, 64'h08);
    op(0, CMD_PRIO, 1'b0, 3'h3, 8'h90);
    chk(interrupt_priority_bytes, 64'h90000000);
    op(0, CMD_TARGET, 1'b0, 3'h4, 8'h01);
    op(0, CMD_TARGET, 1'b1, 3'h5, 8'h01);
    chk(cpu_target_bytes, 64'h0400);
    $display("test config done");
    op(0, CMD_PRIO, 1'b1, 3'h5, 8'h20);
    op(2, 3'h1, 1'b1, 3'h0, 8'hf0);
    @(posedge clock);
    want <= 8'h60;
    wt(4);
    chk({set_pending_bits, clear_pending_bits, 6'h0, irq_out}, 64'h606000);
    op(0, CMD_SET_EN, 1'b1, 3'h5, 8'h0);
    chk(irq_out, 64'h1);
    op(1, 3'h0, 1'b0, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'(SPURIOUS_ID));
    op(1, 3'h0, 1'b1, 3'h0, 8'h0);
    chk({ack_valid, ack_id}, 64'h1ffc05);
    chk({active_state_bits, set_pending_bits}, 64'h2040);
    op(0, CMD_CLR_EN, 1'b1, 3'h5, 8'h0);
    chk({set_enable_bits, active_state_bits}, 64'h0120);
    op(3, 3'h0, 1'b0, 3'h5, 8'h0);
    @(posedge clock);
    want <= 8'h00;
    op(0, CMD_CLR_PEND, 1'b1, 3'h6, 8'h0);
    chk({active_state_bits, set_pending_bits}, 64'h0);
    op(1, 3'h0, 1'b1, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'(SPURIOUS_ID));
    op(0, CMD_CLR_EN, 1'b1, 3'h0, 8'h0);
    chk(set_enable_bits, 64'h01);
    $display("test pending done");
    op(0, CMD_SET_EN, 1'b1, 3'h5, 8'h0);
    op(0, CMD_SET_PEND, 1'b1, 3'h5, 8'h0);
    chk(irq_out, 64'h1);
    op(2, 3'h1, 1'b1, 3'h0, 8'h20);
    chk(irq_out, 64'h0);
    op(2, 3'h0, 1'b1, 3'h0, 8'h21);
    chk(irq_out, 64'h0);
    op(2, 3'h1, 1'b1, 3'h0, 8'h21);
    chk(irq_out, 64'h1);
    op(2, 3'h1, 1'b1, 3'h0, 8'hff);
    chk(irq_out, 64'h1);
    for (int i = 0; i < 8; i++) op(0, CMD_PRIO, 1'b1, i[2:0], PRIO_SILENT);
    wt(2);
    chk(irq_out, 64'h0);
    $display("test signal done");
    op(0, CMD_PRIO, 1'b1, 3'h5, 8'h20);
    op(0, CMD_TARGET, 1'b1, 3'h1, 8'h01);
    op(0, CMD_PRIO, 1'b1, 3'h1, 8'h30);
    op(0, CMD_SET_EN, 1'b1, 3'h1, 8'h0);
    op(0, CMD_SET_PEND, 1'b1, 3'h1, 8'h0);
    op(0, CMD_PRIO, 1'b1, 3'h1, 8'h10);
    op(1, 3'h0, 1'b1, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'h001);
    op(1, 3'h0, 1'b1, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'h005);
    chk(active_state_bits, 64'h22);
    op(3, 3'h0, 1'b0, 3'h1, 8'h0);
    op(3, 3'h0, 1'b0, 3'h5, 8'h0);
    op(0, CMD_CLR_EN, 1'b1, 3'h5, 8'h0);
    chk({set_pending_bits[5], active_state_bits[5]}, 64'h0);
    op(0, CMD_PRIO, 1'b1, 3'h5, 8'h80);
    op(0, CMD_TARGET, 1'b1, 3'h5, 8'h01);
    op(0, CMD_GROUP, 1'b1, 3'h5, 8'h01);
    op(0, CMD_SET_EN, 1'b1, 3'h5, 8'h0);
    chk(security_group_bits, 64'h28);
    op(0, CMD_SET_PEND, 1'b0, 3'h5, 8'h0);
    op(1, 3'h0, 1'b1, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'(SPURIOUS_ID));
    op(1, 3'h0, 1'b0, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'h005);
    op(3, 3'h0, 1'b0, 3'h5, 8'h0);
    $display("test regroup done");
    op(0, CMD_TARGET, 1'b1, 3'h1, 8'h00);
    op(0, CMD_TARGET, 1'b1, 3'h5, 8'h00);
    op(0, CMD_SET_PEND, 1'b1, 3'h1, 8'h0);
    op(1, 3'h0, 1'b1, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'(SPURIOUS_ID));
    op(1, 3'h0, 1'b0, 3'h0, 8'h0);
    chk(ack_id[9:0], 64'(SPURIOUS_ID));
    op(2, 3'h0, 1'b1, 3'h0, 8'hff);
    chk({set_pending_bits, irq_out}, 64'h008);
    $display("test drain done");
    close_out();
  end
endmodule
